// >>> shared/smrp_regs.svh
// Register offsets, field positions, reset values and timing counts of the sleep and pin control
`ifndef SMRP_REGS_SVH
`define SMRP_REGS_SVH
`define SMRP_ADDR_MODE      4'h0
`define SMRP_ADDR_STATUS    4'h1
`define SMRP_ADDR_WAKE_EN   4'h2
`define SMRP_ADDR_DIR_BASE  4'h4
`define SMRP_ADDR_OUT_BASE  4'h8
`define SMRP_ADDR_IN_BASE   4'hC
`define SMRP_MODE_EN_BIT    3
`define SMRP_MODE_SEL_LSB   0
`define SMRP_MODE_RESET     8'h00
`define SMRP_WAKE_EN_RESET  8'hFF
`define SMRP_TAP_TDI_BIT    5
`define SMRP_TAP_TMS_BIT    3
`define SMRP_TAP_TCK_BIT    2
`define SMRP_TAP_PORT       2
`define SMRP_WAKE_LAT_CYC   4'h2
`endif

// >>> shared/smrp_pkg.sv
// Types shared by the sleep and pin control block
package smrp_pkg;
    typedef enum logic [2:0] {
        SMRP_IDLE    = 3'h0,
        SMRP_ADCNR   = 3'h1,
        SMRP_PDOWN   = 3'h2,
        SMRP_PSAVE   = 3'h3,
        SMRP_RSVD4   = 3'h4,
        SMRP_RSVD5   = 3'h5,
        SMRP_STDBY   = 3'h6,
        SMRP_XSTDBY  = 3'h7
    } smrp_mode_t;
    typedef enum logic [1:0] {
        SMRP_RUN   = 2'b00,
        SMRP_SLEEP = 2'b01,
        SMRP_WAKE  = 2'b11
    } smrp_state_t;
    typedef struct packed {
        logic cpu_clk;
        logic io_clk;
        logic adc_clk;
        logic async_clk;
        logic main_osc;
    } smrp_gate_t;
endpackage : smrp_pkg

// >>> shared/smrp_port_if.sv
// Pad bundle between the pin controller and one 8-bit port
interface smrp_port_if;
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] pad_o;
    logic [7:0] pad_oe_n;
    logic [7:0] pull_en;
    logic       tap_keep;
    logic       rst_act;
    modport ctrl (output dir, output out, output tap_keep, output rst_act,
                  input pad_o, input pad_oe_n, input pull_en);
    modport pad  (input dir, input out, input tap_keep, input rst_act,
                  output pad_o, output pad_oe_n, output pull_en);
endinterface : smrp_port_if

// >>> logic/smrp_port_pads.sv
// Pad logic of one 8-bit port: drive, tri-state and pull-ups
`include "smrp_regs.svh"
module smrp_port_pads #(
    parameter int TAP_PORT = 0
) (
    smrp_port_if.pad p
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            // Combinational so tri-state holds even with no clock
            assign p.pad_oe_n[i] = p.rst_act | ~p.dir[i];
            assign p.pad_o[i]    = p.out[i];
            if (TAP_PORT != 0 && (i == `SMRP_TAP_TDI_BIT || i == `SMRP_TAP_TMS_BIT
                                  || i == `SMRP_TAP_TCK_BIT)) begin : g_tap
                assign p.pull_en[i] = p.tap_keep |
                    (~p.rst_act & ~p.dir[i] & p.out[i]);
            end else begin : g_norm
                assign p.pull_en[i] = ~p.rst_act & ~p.dir[i] & p.out[i];
            end
        end
    endgenerate
endmodule : smrp_port_pads

// >>> logic/smrp_sleep_ctrl.sv
// Sleep mode sequencer, clock gating and port register file
//
// Design decisions made here: the strobed register port and the address map.
`include "smrp_regs.svh"
module smrp_sleep_ctrl (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              tap_en,
    input  wire logic              sleep_req,
    input  wire logic [7:0]        wake_irq,
    input  wire logic              wake_ext_async,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    output smrp_pkg::smrp_gate_t   clk_run,
    output logic                   cpu_halted,
    output logic                   sleeping,
    output logic      [31:0]       pad_o,
    output logic      [31:0]       pad_oe_n,
    output logic      [31:0]       pull_en,
    input  wire logic [31:0]       pad_i
);
    import smrp_pkg::*;

    logic [7:0]  mode_ff;
    logic [7:0]  wake_en_ff;
    logic [7:0]  dir_ff [4];
    logic [7:0]  out_ff [4];
    logic [31:0] pin_s1_ff;
    logic [31:0] pin_s2_ff;
    logic        ext_s1_ff;
    logic        ext_s2_ff;
    logic        wake_seen_ff;
    smrp_state_t state_ff;
    smrp_state_t nxt_state;
    smrp_mode_t  act_mode_ff;
    logic [3:0]  wake_cnt_ff;
    logic [7:0]  nxt_rdata;
    logic        wake_any;
    logic        rst_act;
    logic        mode_ok;
    smrp_gate_t  nxt_gate;

    // Reset is the raw pin, so pads release with no clock running
    assign rst_act = ~rstn;

    // Pin inputs pass two flops before use
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_s1_ff <= 32'h0000_0000;
            pin_s2_ff <= 32'h0000_0000;
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= pad_i;
            pin_s2_ff <= pin_s1_ff;
            ext_s1_ff <= wake_ext_async;
            ext_s2_ff <= ext_s1_ff;
        end
    end

    // Register writes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_ff    <= `SMRP_MODE_RESET;
            wake_en_ff <= `SMRP_WAKE_EN_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `SMRP_ADDR_MODE) begin
                mode_ff <= {4'h0, reg_wdata[3:0]};
            end
            if (reg_addr == `SMRP_ADDR_WAKE_EN) begin
                wake_en_ff <= reg_wdata;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_port_regs
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    dir_ff[g] <= 8'h00;
                    out_ff[g] <= 8'h00;
                end else if (reg_wr) begin
                    if (reg_addr == (`SMRP_ADDR_DIR_BASE + 4'(g))) begin
                        dir_ff[g] <= reg_wdata;
                    end
                    if (reg_addr == (`SMRP_ADDR_OUT_BASE + 4'(g))) begin
                        out_ff[g] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // Decode in the strobe cycle so the data stand in the very next cycle
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `SMRP_ADDR_MODE:    nxt_rdata = mode_ff;
            `SMRP_ADDR_STATUS:  nxt_rdata = {4'h0, wake_seen_ff, act_mode_ff};
            `SMRP_ADDR_WAKE_EN: nxt_rdata = wake_en_ff;
            default: begin
                if (reg_addr[3:2] == 2'b01) begin
                    nxt_rdata = dir_ff[reg_addr[1:0]];
                end else if (reg_addr[3:2] == 2'b10) begin
                    nxt_rdata = out_ff[reg_addr[1:0]];
                end else if (reg_addr[3:2] == 2'b11) begin
                    nxt_rdata = pin_s2_ff[8 * reg_addr[1:0] +: 8];
                end
            end
        endcase
    end

    // Data output held only in the cycle after the read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
        end
    end
    assign mode_ok = (mode_ff[2:0] != 3'h4) && (mode_ff[2:0] != 3'h5);

    // Deep modes wake only on external interrupt or reset
    always_comb begin
        case (act_mode_ff)
            SMRP_PDOWN, SMRP_PSAVE, SMRP_STDBY, SMRP_XSTDBY: begin
                wake_any = ext_s2_ff;
            end
            default: begin
                wake_any = ext_s2_ff | (|(wake_irq & wake_en_ff));
            end
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SMRP_RUN: begin
                // Sleep only on an explicit request with sleep enabled
                if (sleep_req && mode_ff[`SMRP_MODE_EN_BIT] && mode_ok) begin
                    nxt_state = SMRP_SLEEP;
                end
            end
            SMRP_SLEEP: begin
                if (wake_any) begin
                    nxt_state = SMRP_WAKE;
                end
            end
            SMRP_WAKE: begin
                if (wake_cnt_ff == 4'h0) begin
                    nxt_state = SMRP_RUN;
                end
            end
            default: nxt_state = SMRP_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= SMRP_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            act_mode_ff <= SMRP_IDLE;
        end else if (state_ff == SMRP_RUN && nxt_state == SMRP_SLEEP) begin
            act_mode_ff <= smrp_mode_t'(mode_ff[2:0]);
        end
    end

    // Short restart delay; every mode, standby included, loads the same count
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wake_cnt_ff <= 4'h0;
        end else if (state_ff == SMRP_SLEEP && wake_any) begin
            wake_cnt_ff <= `SMRP_WAKE_LAT_CYC;
        end else if (wake_cnt_ff != 4'h0) begin
            wake_cnt_ff <= wake_cnt_ff - 4'h1;
        end
    end

    // Sticky wake flag: the wake event wins over a status read clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wake_seen_ff <= 1'b0;
        end else if (state_ff == SMRP_SLEEP && wake_any) begin
            wake_seen_ff <= 1'b1;
        end else if (reg_rd && reg_addr == `SMRP_ADDR_STATUS) begin
            wake_seen_ff <= 1'b0;
        end
    end

    // Clock gating per mode while asleep
    always_comb begin
        nxt_gate = '{cpu_clk: 1'b1, io_clk: 1'b1, adc_clk: 1'b1,
                     async_clk: 1'b1, main_osc: 1'b1};
        if (state_ff == SMRP_SLEEP) begin
            nxt_gate.cpu_clk = 1'b0;
            case (act_mode_ff)
                SMRP_IDLE: begin
                    nxt_gate.io_clk = 1'b1;
                end
                SMRP_ADCNR: begin
                    nxt_gate.io_clk = 1'b0;
                end
                SMRP_PDOWN: begin
                    nxt_gate = '0;
                end
                SMRP_PSAVE: begin
                    nxt_gate = '0;
                    nxt_gate.async_clk = 1'b1;
                end
                SMRP_STDBY: begin
                    nxt_gate = '0;
                    nxt_gate.main_osc = 1'b1;
                end
                SMRP_XSTDBY: begin
                    nxt_gate = '0;
                    nxt_gate.main_osc  = 1'b1;
                    nxt_gate.async_clk = 1'b1;
                end
                default: nxt_gate.cpu_clk = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk_run <= '{cpu_clk: 1'b1, io_clk: 1'b1, adc_clk: 1'b1,
                         async_clk: 1'b1, main_osc: 1'b1};
        end else begin
            clk_run <= nxt_gate;
        end
    end

    assign cpu_halted = (state_ff != SMRP_RUN);
    assign sleeping   = (state_ff == SMRP_SLEEP);

    // Pad bundles, one per port
    generate
        for (g = 0; g < 4; g++) begin : g_port
            smrp_port_if pif ();
            assign pif.dir      = dir_ff[g];
            assign pif.out      = out_ff[g];
            assign pif.rst_act  = rst_act;
            assign pif.tap_keep = tap_en;
            smrp_port_pads #(
                .TAP_PORT ((g == `SMRP_TAP_PORT) ? 1 : 0)
            ) u_pads (
                .p (pif.pad)
            );
            assign pad_o[8*g +: 8]    = pif.pad_o;
            assign pad_oe_n[8*g +: 8] = pif.pad_oe_n;
            assign pull_en[8*g +: 8]  = pif.pull_en;
        end
    endgenerate
endmodule : smrp_sleep_ctrl

// >>> bench/smrp_sleep_checker.sv
// Port assertions for the sleep and pin control block
module smrp_sleep_checker (
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    input wire logic                 tap_en,
    input wire logic                 sleep_req,
    input wire logic                 wake_ext_async,
    input wire logic [7:0]           wake_irq,
    input wire logic [3:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire smrp_pkg::smrp_gate_t clk_run,
    input wire logic                 cpu_halted,
    input wire logic                 sleeping,
    input wire logic [31:0]          pad_oe_n,
    input wire logic [31:0]          pull_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import smrp_pkg::*;
    logic [3:0] mode_ff;
    logic [2:0] act_m_ff;
    logic       take_req;
    // Shadow of the mode register, seen only through bus writes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= 4'h0;
        end else if (reg_wr && reg_addr == 4'h0) begin
            mode_ff <= reg_wdata[3:0];
        end
    end
    assign take_req = sleep_req && !sleeping && !cpu_halted && mode_ff[3]
                      && mode_ff[2:1] != 2'b10;
    // Mode in use, latched as the request is taken; bit 1 marks the deep modes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            act_m_ff <= 3'h0;
        end else if (take_req) begin
            act_m_ff <= mode_ff[2:0];
        end
    end
    function automatic logic [4:0] gate_of(input logic [2:0] m);
        case (m)
            3'h0: gate_of = 5'h0F;
            3'h1: gate_of = 5'h07;
            3'h3: gate_of = 5'h02;
            3'h6: gate_of = 5'h01;
            3'h7: gate_of = 5'h03;
            default: gate_of = 5'h00;
        endcase
    endfunction : gate_of
    // Reset checks carry no disable: they must hold while reset is low
    a_reset_tristate: assert property (@(posedge clk_sys) !rstn |-> &pad_oe_n)
        else $error("pins driven during reset");
    a_reset_pull: assert property (@(posedge clk_sys) !rstn |->
        pull_en == (tap_en ? 32'h002C0000 : 32'h0)) else $error("pull-ups wrong in reset");
    a_tap_pullup: assert property (@(posedge clk_sys) tap_en |->
        (pull_en[23:16] & 8'h2C) == 8'h2C) else $error("test pin pull-up lost");
    a_sleep_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
        take_req |=> sleeping) else $error("sleep request not taken");
    a_sleep_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
        sleep_req && !sleeping && !cpu_halted && !take_req |=> !sleeping)
        else $error("refused sleep request taken");
    a_gate_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        sleeping && $past(sleeping) |-> clk_run == gate_of(act_m_ff))
        else $error("clock gating wrong for mode");
    a_wake_exit: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(wake_ext_async) && sleeping |-> ##3 !sleeping) else $error("wake too slow");
    a_sleep_stays: assert property (@(posedge clk_sys) disable iff (!rstn)
        (sleeping && !wake_ext_async && (act_m_ff[1] || !(|wake_irq))) [*3] |=> sleeping)
        else $error("woke with no cause");
    a_wake_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(sleeping) |-> cpu_halted ##3 !cpu_halted) else $error("resume delay wrong");
    a_resume_clk: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(cpu_halted) |-> clk_run == 5'h1F) else $error("clocks not back on resume");
    c_sleep: cover property (@(posedge clk_sys) disable iff (!rstn) take_req);
    c_wake: cover property (@(posedge clk_sys) disable iff (!rstn) $fell(sleeping));
    c_tap_reset: cover property (@(posedge clk_sys) !rstn && tap_en);
    c_irq_wake: cover property (@(posedge clk_sys) disable iff (!rstn)
        sleeping && !act_m_ff[1] && |wake_irq);
endmodule : smrp_sleep_checker
bind smrp_sleep_ctrl smrp_sleep_checker chk (.clk_sys, .rstn, .tap_en, .sleep_req,
    .wake_ext_async, .wake_irq, .reg_addr, .reg_wdata, .reg_wr, .clk_run, .cpu_halted, .sleeping,
    .pad_oe_n, .pull_en);

// >>> bench/smrp_ext_party.sv
// Far side model: reset source, external wake line and the pins
module smrp_ext_party (
    input  wire logic        rst_cmd,
    input  wire logic        wake_cmd,
    input  wire logic [31:0] pin_ext,
    input  wire logic [31:0] pad_o,
    input  wire logic [31:0] pad_oe_n,
    input  wire logic [31:0] pull_en,
    output logic             rstn,
    output logic             wake_ext_async,
    output logic [31:0]      pad_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // A level, not a pulse: the bench holds it for the minimum length
    assign rstn = !rst_cmd;
    assign wake_ext_async = wake_cmd;
    // Pull-up wins over the outside level, so a floating pin never reads the last drive
    assign pad_i = (~pad_oe_n & pad_o) | (pad_oe_n & (pull_en | pin_ext));
endmodule : smrp_ext_party

// >>> bench/test_sleep_mode_and_reset_pin_control.sv
// Self-checking bench for the sleep and pin control block
module test_sleep_mode_and_reset_pin_control;
    timeunit 1ns;
    timeprecision 1ps;
    import smrp_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_cmd = 1'b1;
    logic        tap_en = 1'b1;
    logic        sleep_req = 1'b0;
    logic        wake_cmd = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  wake_irq = 8'h00;
    logic [31:0] pin_ext = 32'hFFFFFFFF;
    logic        rstn, wake_ext_async, cpu_halted, sleeping;
    logic [7:0]  reg_rdata;
    logic [31:0] pad_o, pad_oe_n, pull_en, pad_i;
    smrp_gate_t  clk_run;
    int          miscompares = 0;
    int          n_checks = 0;
    logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [4:0]  gates [6] = '{5'h0F, 5'h07, 5'h00, 5'h02, 5'h01, 5'h03};
    smrp_sleep_ctrl uut (.clk_sys, .rstn, .tap_en, .sleep_req, .wake_irq, .wake_ext_async,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clk_run, .cpu_halted,
        .sleeping, .pad_o, .pad_oe_n, .pull_en, .pad_i);
    smrp_ext_party far (.rst_cmd, .wake_cmd, .pin_ext, .pad_o, .pad_oe_n, .pull_en, .rstn,
        .wake_ext_async, .pad_i);
    always #5 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // One idle edge so a following write never lowers and raises the strobe at once
        @(posedge clk_sys);
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        // Data stand only in this cycle; look mid-cycle, away from the launching edge
        @(negedge clk_sys);
        chk(what, exp, reg_rdata);
        @(posedge clk_sys);
    endtask : rd_chk
    task automatic t_reset();
        wr(4'h4, 8'hFF);
        wr(4'h8, 8'h5A);
        @(posedge clk_sys);
        chk("port0 drive", 32'h5A00, {pad_o[7:0], pad_oe_n[7:0]});
        rst_cmd <= 1'b1;
        // No edge between reset and the check: release must not wait for the clock
        #1;
        chk("pins released", 32'hFFFFFFFF, pad_oe_n);
        chk("test pulls", 32'h002C0000, pull_en);
        repeat (3) @(posedge clk_sys);
        tap_en <= 1'b0;
        @(posedge clk_sys);
        chk("pulls off", 32'h0, pull_en);
        rst_cmd <= 1'b0;
        @(posedge clk_sys);
    endtask : t_reset
    task automatic t_pull();
        pin_ext <= 32'h0;
        wr(4'h5, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(4'h9, i ? 8'h5A : 8'hA5);
            repeat (3) @(posedge clk_sys);
            chk("port1 pulls", i ? 8'h5A : 8'hA5, pull_en[15:8]);
            rd_chk(4'hD, i ? 8'h5A : 8'hA5, "port1 pins");
        end
    endtask : t_pull
    task automatic t_refuse();
        for (int i = 0; i < 3; i++) begin
            wr(i ? 4'h0 : 4'h3, i == 1 ? 8'h02 : 8'h0C);
            sleep_req <= 1'b1;
            @(posedge clk_sys);
            sleep_req <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk("refused sleep", 0, sleeping);
        end
        rd_chk(4'h3, 8'h00, "unmapped");
        rd_chk(4'h0, 8'h0C, "mode");
        rd_chk(4'h2, 8'hFF, "wake enable");
    endtask : t_refuse
    task automatic t_modes();
        for (int i = 0; i < 6; i++) begin
            wr(4'h0, {5'h01, modes[i]});
            sleep_req <= 1'b1;
            @(posedge clk_sys);
            sleep_req <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk("sleeping", {1'b1, gates[i]}, {sleeping, clk_run});
            wake_cmd <= 1'b1;
            for (int n = 0; n < 20 && cpu_halted !== 1'b0; n++) @(posedge clk_sys);
            chk("resumed", 5'h1F, {cpu_halted, clk_run});
            wake_cmd <= 1'b0;
            rd_chk(4'h1, {5'h01, modes[i]}, "status");
        end
    endtask : t_modes
    // Idle wakes on an enabled internal line only; power-down ignores internal lines
    task automatic t_irq();
        wr(4'h2, 8'h01);
        for (int i = 0; i < 2; i++) begin
            wr(4'h0, i ? 8'h0A : 8'h08);
            sleep_req <= 1'b1;
            @(posedge clk_sys);
            sleep_req <= 1'b0;
            wake_irq <= 8'h02;
            repeat (4) @(posedge clk_sys);
            chk("masked irq", 1, sleeping);
            wake_irq <= 8'h01;
            repeat (2) @(posedge clk_sys);
            chk("irq wake", i, sleeping);
            wake_irq <= 8'h00;
            wake_cmd <= (i == 1);
            for (int n = 0; n < 20 && cpu_halted !== 1'b0; n++) @(posedge clk_sys);
            chk("irq resumed", 0, cpu_halted);
            wake_cmd <= 1'b0;
            rd_chk(4'h1, i ? 8'h0A : 8'h08, "irq status");
        end
    endtask : t_irq
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_cmd <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_pull();
        t_refuse();
        t_modes();
        t_irq();
        print_verdict();
    end
endmodule : test_sleep_mode_and_reset_pin_control
